// >>> hw/sfcpd_pkg.sv
// package: opcodes, bit counts, timing and host register map for the flash command block
package sfcpd_pkg;

  // ----------------------------------------------------------------
  // instruction opcodes, erase fill byte and no-protect value
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_ERASE_A = 8'hC7;
  localparam logic [7:0] OP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
  localparam logic [7:0] OP_RELEASE = 8'hAB;
  localparam logic [7:0] ERASE_FILL = 8'hFF;
  localparam logic [3:0] BP_NONE = 4'h0;

  // ----------------------------------------------------------------
  // frame bit positions (bits counted from chip select falling)
  // ----------------------------------------------------------------
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] ID_START_BITS = 6'h20;
  localparam logic [5:0] ID_LAST_BIT = 6'h27;

  // ----------------------------------------------------------------
  // timing: times in ns, counts derived at the system clock rate
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned T_DP_NS = 3000;
  localparam int unsigned RELEASE_TIME_PLAIN_NS = 3000;
  localparam int unsigned RELEASE_TIME_WITH_IDENTIFIER_NS = 1800;
  localparam int unsigned DP_CYCLES = (T_DP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RES1_CYCLES = (RELEASE_TIME_PLAIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RES2_CYCLES = (RELEASE_TIME_WITH_IDENTIFIER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYCLES = (RES1_CYCLES > RES2_CYCLES) ? RES1_CYCLES : RES2_CYCLES;
  localparam logic [2:0] HALF_DIV = 3'h4;

  // ----------------------------------------------------------------
  // host command port map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] HOST_CMD_ADDR = 8'h00;
  localparam logic [7:0] HOST_STAT_ADDR = 8'h04;
  localparam int unsigned CMD_DUMMY_LSB = 8;
  localparam int unsigned CMD_READ_BIT = 10;
  localparam int unsigned STAT_ID_LSB = 8;

  typedef enum logic [2:0] {
    DEV_IDLE,
    DEV_ERASING,
    DEV_PD_ENTRY,
    DEV_POWERED_DOWN,
    DEV_RELEASING
  } sfcpd_dev_state_t;

  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_SHIFT,
    HOST_GAP
  } sfcpd_host_state_t;

endpackage

// >>> hw/sfcpd_spi_if.sv
// interface: serial link between the flash command block and its host
`timescale 1ns/1ps
`default_nettype none

interface sfcpd_spi_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;

  modport device (input cs_n, input sclk, input mosi, output miso);
  modport host (output cs_n, output sclk, output mosi, input miso);
endinterface

`default_nettype wire

// >>> hw/sfcpd_flash_dev.sv
// design: flash device end handling array erase, deep power-down and release/identifier
//
// Overview of operation
// - accepted erase opcode C7h/60h fills array with FFh
// - erase accepted only with write enable latch set
// - host sends erase as bare opcode, select low
// - erase runs only if select rises after bit eight
// - select rise starts timed erase, busy, latch cleared
// - erase ignored unless all protect bits are zero
// - opcode B9h enters deep power-down, writes ignored
// - select high gives standby, never deep power-down
// - in power-down only ABh is obeyed, releasing
// - reset always comes up in standby
// - power-down needs exact eight bits, then entry delay
// - power-down during busy cycle rejected, cycle unaffected
// - plain release: ABh, select high for release time
// - ABh plus three dummies streams identifier msb first
// - release delay only when previously powered down
// - identifier always available, not decoded while busy
// - new hosts should prefer the standard identification read
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module sfcpd_flash_dev
  import sfcpd_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = 100_000,
  parameter logic [7:0] DEVICE_ID = 8'h5A // arbitrary value
)
(
  input wire logic clk_in,
  input wire logic srst_in,
  sfcpd_spi_if.device spi,
  input wire logic [3:0] block_protect_bits_in,
  output logic write_in_progress_out,
  output logic write_enable_latch_out,
  output logic deep_power_down_out,
  output logic erase_strobe_out,
  output logic [7:0] erase_fill_out
);

  // ----------------------------------------------------------------
  // link domain: bit capture on the serial clock
  // ----------------------------------------------------------------
  logic frame_start_reg;
  logic [5:0] bit_cnt_reg;
  logic [7:0] opcode_reg;
  logic busy_s1_reg;
  logic busy_s2_reg;
  logic miso_reg;
  logic write_in_progress_reg;

  // armed while select is high so the next rising edge restarts the count
  always_ff @(posedge spi.sclk or posedge spi.cs_n)
  begin
    if (spi.cs_n)
    begin
      frame_start_reg <= 1'b1;
    end
    else
    begin
      frame_start_reg <= 1'b0;
    end
  end

  // opcode shift and bit counter; counter wraps inside the identifier byte
  // not cleared by select so the system side can read them after the frame
  always_ff @(posedge spi.sclk)
  begin
    if (frame_start_reg)
    begin
      bit_cnt_reg <= 6'h01;
      opcode_reg <= {7'h00, spi.mosi};
    end
    else
    begin
      if (bit_cnt_reg < OPCODE_BITS)
        opcode_reg <= {opcode_reg[6:0], spi.mosi};
      if (bit_cnt_reg == ID_LAST_BIT)
        bit_cnt_reg <= ID_START_BITS;
      else
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
    end
  end

  // busy level into the link domain; enough edges pass during the opcode
  always_ff @(posedge spi.sclk)
  begin
    busy_s1_reg <= write_in_progress_reg;
    busy_s2_reg <= busy_s1_reg;
  end

  // identifier out on falling edges after opcode and three dummy bytes
  always_ff @(negedge spi.sclk or posedge spi.cs_n)
  begin
    if (spi.cs_n)
      miso_reg <= 1'b0;
    else if ((bit_cnt_reg >= ID_START_BITS) && (opcode_reg == OP_RELEASE) && !busy_s2_reg)
      miso_reg <= DEVICE_ID[~bit_cnt_reg[2:0]];
    else
      miso_reg <= 1'b0;
  end

  assign spi.miso = miso_reg;

  // ----------------------------------------------------------------
  // system domain: frame end detection
  // ----------------------------------------------------------------
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic cs_s3_reg;
  logic frame_end;

  // select passes two flops; third one only for the rising edge
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
    end
    else
    begin
      cs_s1_reg <= spi.cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
    end
  end

  // opcode and count are frozen once the clock stops before select rises
  assign frame_end = cs_s2_reg && !cs_s3_reg;

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  logic exact_eight;
  logic erase_cmd;
  logic erase_go;
  logic write_enable_cmd_go;
  logic pd_go;
  logic release_cmd;
  logic write_enable_latch_reg;
  sfcpd_dev_state_t state_reg;
  sfcpd_dev_state_t state_next;
  logic [31:0] timer_reg;
  logic [31:0] timer_next;

  assign exact_eight = (bit_cnt_reg == OPCODE_BITS);
  assign erase_cmd = (opcode_reg == OP_ERASE_A) || (opcode_reg == OP_ERASE_B);
  // all other instructions are dropped outside standby
  assign erase_go = frame_end && (state_reg == DEV_IDLE) && exact_eight && erase_cmd
                    && write_enable_latch_reg
                    && (block_protect_bits_in == BP_NONE);
  assign write_enable_cmd_go = frame_end && (state_reg == DEV_IDLE) && exact_eight
                   && (opcode_reg == OP_WRITE_ENABLE);
  assign pd_go = frame_end && (state_reg == DEV_IDLE) && exact_eight
                 && (opcode_reg == OP_POWER_DOWN);
  assign release_cmd = frame_end && (opcode_reg == OP_RELEASE)
                       && (bit_cnt_reg >= OPCODE_BITS);

  // ----------------------------------------------------------------
  // operating state and self-timed cycles
  // ----------------------------------------------------------------
  // a busy erase ignores every frame, so a running cycle is never disturbed
  always_comb
  begin
    state_next = state_reg;
    timer_next = timer_reg;
    case (state_reg)
      DEV_IDLE:
      begin
        if (erase_go)
        begin
          state_next = DEV_ERASING;
          timer_next = ERASE_CYCLES - 1;
        end
        else if (pd_go)
        begin
          state_next = DEV_PD_ENTRY;
          timer_next = DP_CYCLES - 1;
        end
      end
      DEV_POWERED_DOWN:
      begin
        if (release_cmd)
        begin
          state_next = DEV_RELEASING;
          // a bare opcode is the plain release, a longer frame also read the identifier
          timer_next = exact_eight ? RES1_CYCLES - 1 : RES2_CYCLES - 1;
        end
      end
      // the three self-timed states share one down-counter
      DEV_ERASING, DEV_PD_ENTRY, DEV_RELEASING:
      begin
        if (timer_reg != 32'h0000_0000)
        begin
          timer_next = timer_reg - 32'h0000_0001;
        end
        else if (state_reg == DEV_PD_ENTRY)
        begin
          state_next = DEV_POWERED_DOWN;
        end
        else
        begin
          state_next = DEV_IDLE;
        end
      end
      default:
      begin
        state_next = DEV_IDLE;
        timer_next = 32'h0000_0000;
      end
    endcase
  end

  // reset always lands in standby, never in deep power-down
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      state_reg <= DEV_IDLE;
      timer_reg <= 32'h0000_0000;
    end
    else
    begin
      state_reg <= state_next;
      timer_reg <= timer_next;
    end
  end

  // latch set by its own command, cleared as the erase cycle starts
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      write_enable_latch_reg <= 1'b0;
    else if (write_enable_cmd_go)
      write_enable_latch_reg <= 1'b1;
    else if (erase_go)
      write_enable_latch_reg <= 1'b0;
  end

  // status outputs registered from the next state; erase strobe registered from erase_go
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      write_in_progress_reg <= 1'b0;
      deep_power_down_out <= 1'b0;
      erase_strobe_out <= 1'b0;
    end
    else
    begin
      write_in_progress_reg <= (state_next == DEV_ERASING);
      deep_power_down_out <= (state_next == DEV_POWERED_DOWN)
                             || (state_next == DEV_RELEASING);
      erase_strobe_out <= erase_go;
    end
  end

  assign write_in_progress_out = write_in_progress_reg;
  assign write_enable_latch_out = write_enable_latch_reg;
  assign erase_fill_out = ERASE_FILL;

endmodule

`default_nettype wire

// >>> hw/sfcpd_flash_host.sv
// design: host end that sends one instruction frame per command write
`timescale 1ns/1ps
`default_nettype none

module sfcpd_flash_host
  import sfcpd_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  sfcpd_spi_if.host spi,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out
);

  sfcpd_host_state_t state_reg;
  logic [2:0] tick_reg;
  logic [5:0] bits_left_reg;
  logic [31:0] tx_reg;
  logic [7:0] rx_reg;
  logic [7:0] id_reg;
  logic [31:0] gap_reg;
  logic sclk_reg;
  logic cs_n_reg;
  logic mosi_reg;
  logic miso_s1_reg;
  logic miso_s2_reg;
  logic go;
  logic [5:0] frame_bits;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // writes while a frame or hold time runs are dropped; status shows busy
  assign go = wr_in && (addr_in == HOST_CMD_ADDR) && (state_reg == HOST_IDLE);
  // opcode, 0..3 dummy bytes, optional identifier byte
  assign frame_bits = OPCODE_BITS + {1'b0, wdata_in[CMD_DUMMY_LSB +: 2], 3'h0}
                      + (wdata_in[CMD_READ_BIT] ? OPCODE_BITS : 6'h00);

  // returning data line from the other domain
  always_ff @(posedge clk_in)
  begin
    miso_s1_reg <= spi.miso;
    miso_s2_reg <= miso_s1_reg;
  end

  // ----------------------------------------------------------------
  // frame sequencer; the serial clock is a divided system clock
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      state_reg <= HOST_IDLE;
      tick_reg <= 3'h0;
      bits_left_reg <= 6'h00;
      tx_reg <= 32'h0000_0000;
      rx_reg <= 8'h00;
      id_reg <= 8'h00;
      gap_reg <= 32'h0000_0000;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      mosi_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        HOST_IDLE:
        begin
          if (go)
          begin
            state_reg <= HOST_SHIFT;
            cs_n_reg <= 1'b0;
            tx_reg <= {wdata_in[7:0], 24'h00_0000}; // dummy bytes are zero
            mosi_reg <= wdata_in[7];
            bits_left_reg <= frame_bits;
            tick_reg <= 3'h0;
          end
        end
        HOST_SHIFT:
        begin
          if (tick_reg == HALF_DIV - 3'h1)
          begin
            tick_reg <= 3'h0;
            if (!sclk_reg)
            begin
              sclk_reg <= 1'b1;
              rx_reg <= {rx_reg[6:0], miso_s2_reg};
            end
            else
            begin
              sclk_reg <= 1'b0;
              if (bits_left_reg == 6'h01)
              begin
                cs_n_reg <= 1'b1;
                id_reg <= rx_reg;
                state_reg <= HOST_GAP;
                gap_reg <= HOLD_CYCLES - 1;
              end
              else
              begin
                bits_left_reg <= bits_left_reg - 6'h01;
                tx_reg <= {tx_reg[30:0], 1'b0};
                mosi_reg <= tx_reg[30];
              end
            end
          end
          else
          begin
            tick_reg <= tick_reg + 3'h1;
          end
        end
        HOST_GAP:
        begin
          // select stays high long enough for either release time
          if (gap_reg == 32'h0000_0000)
          begin
            state_reg <= HOST_IDLE;
          end
          else
          begin
            gap_reg <= gap_reg - 32'h0000_0001;
          end
        end
        default:
        begin
          state_reg <= HOST_IDLE;
        end
      endcase
    end
  end

  assign spi.cs_n = cs_n_reg;
  assign spi.sclk = sclk_reg;
  assign spi.mosi = mosi_reg;

  // ----------------------------------------------------------------
  // status read, data one cycle after the strobe
  // ----------------------------------------------------------------
  // the identifier byte is the legacy one; prefer the standard read
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rdata_out <= 32'h0000_0000;
    end
    else if (rd_in && (addr_in == HOST_STAT_ADDR))
    begin
      rdata_out <= {16'h0000, id_reg, 7'h00, (state_reg != HOST_IDLE)};
    end
    else
    begin
      rdata_out <= 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// >>> verification/sfcpd_monitor.sv
// checker: timing relations on the flash link and the device status outputs
`timescale 1ns/1ps
`default_nettype none

module sfcpd_monitor
  import sfcpd_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = 100_000
)
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic [3:0] block_protect_bits_in,
  input wire logic write_in_progress_out,
  input wire logic write_enable_latch_out,
  input wire logic deep_power_down_out,
  input wire logic erase_strobe_out,
  input wire logic [7:0] erase_fill_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  logic [10:0] sel_high_reg;
  logic [31:0] busy_len_reg;

  // cycles since select rose, saturating so long idles cannot wrap
  always_ff @(posedge clk_in)
  begin
    if (srst_in || !cs_n)
      sel_high_reg <= 11'h000;
    else if (sel_high_reg != 11'h7ff)
      sel_high_reg <= sel_high_reg + 11'h001;
  end

  // length of the current busy stretch
  always_ff @(posedge clk_in)
  begin
    if (srst_in || !write_in_progress_out)
      busy_len_reg <= 32'h0000_0000;
    else
      busy_len_reg <= busy_len_reg + 32'h0000_0001;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sclk_quiet_a: assert property (cs_n |-> !sclk)
    else $error("serial clock moving while deselected");
  erase_busy_a: assert property (erase_strobe_out |=> write_in_progress_out)
    else $error("erase started without busy");
  erase_latch_a: assert property (erase_strobe_out |=> !write_enable_latch_out)
    else $error("latch still set after erase start");
  erase_once_a: assert property (erase_strobe_out |=> !erase_strobe_out)
    else $error("erase strobe longer than one cycle");
  erase_len_a: assert property (
    $fell(write_in_progress_out) && !$past(srst_in) |->
    busy_len_reg >= ERASE_CYCLES - 1 && busy_len_reg <= ERASE_CYCLES + 1)
    else $error("erase busy length wrong");
  erase_guard_a: assert property (erase_strobe_out |->
    cs_n && block_protect_bits_in == BP_NONE && !deep_power_down_out)
    else $error("erase accepted while protected or asleep");
  busy_start_a: assert property ($rose(write_in_progress_out) |-> cs_n)
    else $error("busy began while still selected");
  fill_ones_a: assert property (erase_fill_out == ERASE_FILL)
    else $error("erase fill value not all ones");
  pd_entry_a: assert property ($rose(deep_power_down_out) |->
    sel_high_reg >= 11'(DP_CYCLES))
    else $error("power-down entered before entry delay");
  pd_exit_a: assert property (
    $fell(deep_power_down_out) && !$past(srst_in) |-> sel_high_reg >= 11'(RES2_CYCLES))
    else $error("release finished before release time");
  // the identifier line must rest low whenever the device is deselected
  miso_idle_a: assert property (cs_n |-> !miso)
    else $error("identifier line active while deselected");
  // host data may only move while the serial clock is low
  mosi_steady_a: assert property ($changed(mosi) |-> !sclk)
    else $error("host data moved while serial clock high");

  c_erase: cover property (erase_strobe_out);
  c_sleep: cover property ($rose(deep_power_down_out));
  c_wake: cover property ($fell(deep_power_down_out));
endmodule

`default_nettype wire

// >>> verification/test_serial_flash_chip_erase_power_down.sv
// testbench: host register port driving the flash device end over the serial link
`timescale 1ns/1ps
`default_nettype none

module test_serial_flash_chip_erase_power_down
  import sfcpd_pkg::*;
;
  localparam int unsigned ERASE_LEN = 1500; // long enough to overlap two later frames
  localparam logic [7:0] ID_VAL = 8'hA5; // arbitrary value
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [3:0] protect = 4'h0;
  logic [31:0] rdata_out;
  logic write_in_progress;
  logic write_enable_latch;
  logic dpd;
  logic strobe;
  logic [7:0] fill;
  int miscompares = 0;
  int n_checks = 0;
  int n_strobe = 0;
  int cycles = 0;

  // ----------------------------------------------------------------
  // the two ends joined over the link
  // ----------------------------------------------------------------
  sfcpd_spi_if sfcpd_spi_if_i ();
  sfcpd_flash_dev #(.ERASE_CYCLES(ERASE_LEN), .DEVICE_ID(ID_VAL)) sfcpd_flash_dev_i (
    .clk_in(clk_in), .srst_in(srst_in), .spi(sfcpd_spi_if_i.device),
    .block_protect_bits_in(protect), .write_in_progress_out(write_in_progress),
    .write_enable_latch_out(write_enable_latch), .deep_power_down_out(dpd),
    .erase_strobe_out(strobe), .erase_fill_out(fill));
  sfcpd_flash_host sfcpd_flash_host_i (
    .clk_in(clk_in), .srst_in(srst_in), .spi(sfcpd_spi_if_i.host), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out));
  sfcpd_monitor #(.ERASE_CYCLES(ERASE_LEN)) sfcpd_monitor_i (
    .clk_in(clk_in), .srst_in(srst_in), .cs_n(sfcpd_spi_if_i.cs_n),
    .sclk(sfcpd_spi_if_i.sclk), .mosi(sfcpd_spi_if_i.mosi), .miso(sfcpd_spi_if_i.miso),
    .block_protect_bits_in(protect), .write_in_progress_out(write_in_progress),
    .write_enable_latch_out(write_enable_latch), .deep_power_down_out(dpd),
    .erase_strobe_out(strobe), .erase_fill_out(fill));

  initial
  begin
    forever #5 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    if (miscompares == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // erase pulses are one cycle wide, so count them as they pass
  always @(posedge clk_in)
  begin
    cycles++;
    if (strobe === 1'b1)
      n_strobe++;
    if (cycles == 40000)
    begin
      miscompares++;
      close_out();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask

  // send one frame and poll busy, bounded so a stuck host cannot hang the run
  task automatic cmd(input logic [7:0] op, input logic [1:0] dum, input logic rd,
    output logic [7:0] got);
    logic [31:0] st;
    int n;
    bus_wr(HOST_CMD_ADDR, {21'h00_0000, rd, dum, op});
    st = 32'h0000_0001;
    n = 0;
    while (st[0] !== 1'b0 && n < 3000)
    begin
      bus_rd(HOST_STAT_ADDR, st);
      n++;
    end
    check({7'h00, st[0]}, 8'h00);
    got = st[15:8];
  endtask

  task automatic wait_dpd(input logic v, input int lim);
    int n;
    n = 0;
    while (dpd !== v && n < lim)
    begin
      @(posedge clk_in);
      n++;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_refuse();
    logic [7:0] g;
    cmd(OP_ERASE_A, 2'h0, 1'b0, g);
    check(n_strobe[7:0], 8'h00);
    cmd(OP_WRITE_ENABLE, 2'h0, 1'b0, g);
    check({7'h00, write_enable_latch}, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_in);
      protect <= 4'h1 << i;
      cmd(OP_ERASE_A, 2'h0, 1'b0, g);
      check({write_enable_latch, write_in_progress, n_strobe[5:0]}, 8'h80);
    end
    @(posedge clk_in);
    protect <= BP_NONE;
    // a trailing byte after the opcode must void the erase
    cmd(OP_ERASE_A, 2'h1, 1'b0, g);
    check({write_enable_latch, write_in_progress, n_strobe[5:0]}, 8'h80);
  endtask

  task automatic t_erase();
    logic [7:0] g;
    logic [7:0] ops [2];
    int n;
    ops = '{OP_ERASE_A, OP_ERASE_B};
    for (int k = 0; k < 2; k++)
    begin
      cmd(OP_WRITE_ENABLE, 2'h0, 1'b0, g);
      cmd(ops[k], 2'h0, 1'b0, g);
      check(n_strobe[7:0], 8'(k + 1));
      check({6'h00, write_enable_latch, write_in_progress}, 8'h01);
      // frames landing mid-erase must leave it running
      cmd(OP_POWER_DOWN, 2'h0, 1'b0, g);
      repeat (20) @(posedge clk_in);
      check({6'h00, dpd, write_in_progress}, 8'h01);
      cmd(OP_RELEASE, 2'h3, 1'b1, g);
      check(g, 8'h00);
      n = 0;
      while (write_in_progress !== 1'b0 && n < 2000)
      begin
        @(posedge clk_in);
        n++;
      end
      check({dpd, write_in_progress, n_strobe[5:0]}, 8'(k + 1));
    end
  endtask

  task automatic t_power();
    logic [7:0] g;
    cmd(OP_POWER_DOWN, 2'h1, 1'b0, g);
    repeat (320) @(posedge clk_in);
    check({7'h00, dpd}, 8'h00);
    cmd(OP_POWER_DOWN, 2'h0, 1'b0, g);
    wait_dpd(1'b1, 400);
    check({7'h00, dpd}, 8'h01);
    cmd(OP_WRITE_ENABLE, 2'h0, 1'b0, g);
    cmd(OP_ERASE_A, 2'h0, 1'b0, g);
    check({write_enable_latch, write_in_progress, n_strobe[5:0]}, 8'h02);
    cmd(OP_RELEASE, 2'h0, 1'b0, g);
    wait_dpd(1'b0, 400);
    check({7'h00, dpd}, 8'h00);
    cmd(OP_RELEASE, 2'h3, 1'b1, g);
    check(g, ID_VAL);
    cmd(OP_POWER_DOWN, 2'h0, 1'b0, g);
    wait_dpd(1'b1, 400);
    cmd(OP_RELEASE, 2'h3, 1'b1, g);
    wait_dpd(1'b0, 400);
    check({7'h00, dpd}, 8'h00);
    // a reset while asleep must bring the device back in standby
    cmd(OP_POWER_DOWN, 2'h0, 1'b0, g);
    wait_dpd(1'b1, 400);
    check({7'h00, dpd}, 8'h01);
    @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    check({7'h00, dpd}, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    check({4'h0, write_in_progress, write_enable_latch, dpd, strobe}, 8'h00);
    check(fill, ERASE_FILL);
    t_refuse();
    t_erase();
    t_power();
    close_out();
  end
endmodule

`default_nettype wire
